/* File: oam_local_status_regs.sv */
// Top of the local status register bank with partner shadow and interrupt logic.
// Assumes an AHB-Lite master on hclk and asynchronous status pins from the board.
// Register index i sits at byte address 4*i; data sits in the low byte.
`default_nettype none
module oam_local_status_regs (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output var  logic        hreadyout,
	output var  logic        hresp,
	output var  logic [31:0] hrdata,
	input  wire logic        por_n,
	input  wire logic        terminal_role,
	input  wire logic        center_loop_state_a,
	input  wire logic        center_loop_state_b,
	input  wire logic        terminal_loop_state,
	input  wire logic        loss_notify_pin,
	input  wire logic        diag_fail_pin,
	input  wire logic        copper_link_down_hw,
	input  wire logic        fibre_signal_detect_pin,
	input  wire logic        power_down_pin_n,
	input  wire logic        copper_autoneg_strap,
	input  wire logic        opt_link_up,
	input  wire logic [7:0]  partner_status,
	output var  logic        irq
);
	logic       wr_stb;
	logic       rd_take;
	logic [7:0] acc_addr;
	logic       role_s;
	logic       notify_s;
	logic       diag_s;
	logic       sd_s;
	logic       pdn_s;
	logic       aneg_s;
	logic       loop_s;
	logic       link_s;
	logic       culd_s;
	logic       loop_any;

	logic [7:0] stat1_reg;
	logic [7:0] stat1_next;
	logic [7:0] stat2_reg;
	logic [7:0] stat2_next;
	logic [7:0] shadow_reg;
	logic [7:0] shadow_next;
	logic [3:0] irq_st_reg;
	logic [3:0] irq_st_next;
	logic [3:0] irq_msk_reg;
	logic [3:0] irq_msk_next;
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;
	logic       osl_d_reg;
	logic       culd_d_reg;
	logic       loop_d_reg;
	logic       init_done_reg;
	logic       init_done_next;
	logic       strap_done_reg;
	olsr_pkg::olsr_shadow_state_t sh_state_reg;
	olsr_pkg::olsr_shadow_state_t sh_state_next;

	// Bus front end.
	olsr_ahb_slave u_bus (
		.hclk      (hclk),
		.hresetn   (hresetn),
		.hsel      (hsel),
		.haddr     (haddr),
		.htrans    (htrans),
		.hwrite    (hwrite),
		.hready    (hready),
		.hreadyout (hreadyout),
		.hresp     (hresp),
		.wr_stb    (wr_stb),
		.rd_stb    (),
		.acc_addr  (acc_addr)
	);

	// Pin synchronisers; each pin passes four flops before use.
	olsr_sync #(.RST_VAL(1'b0)) u_role (
		.hclk(hclk), .hresetn(hresetn), .pin_in(terminal_role), .level_out(role_s));
	olsr_sync #(.RST_VAL(1'b0)) u_notify (
		.hclk(hclk), .hresetn(hresetn), .pin_in(loss_notify_pin), .level_out(notify_s));
	olsr_sync #(.RST_VAL(1'b0)) u_diag (
		.hclk(hclk), .hresetn(hresetn), .pin_in(diag_fail_pin), .level_out(diag_s));
	olsr_sync #(.RST_VAL(1'b0)) u_sd (
		.hclk(hclk), .hresetn(hresetn), .pin_in(fibre_signal_detect_pin), .level_out(sd_s));
	olsr_sync #(.RST_VAL(1'b1)) u_pdn (
		.hclk(hclk), .hresetn(hresetn), .pin_in(power_down_pin_n), .level_out(pdn_s));
	olsr_sync #(.RST_VAL(1'b0)) u_aneg (
		.hclk(hclk), .hresetn(hresetn), .pin_in(copper_autoneg_strap), .level_out(aneg_s));
	olsr_sync #(.RST_VAL(1'b0)) u_loop (
		.hclk(hclk), .hresetn(hresetn), .pin_in(loop_any), .level_out(loop_s));
	olsr_sync #(.RST_VAL(1'b0)) u_link (
		.hclk(hclk), .hresetn(hresetn), .pin_in(opt_link_up), .level_out(link_s));
	olsr_sync #(.RST_VAL(1'b1)) u_culd (
		.hclk(hclk), .hresetn(hresetn), .pin_in(copper_link_down_hw), .level_out(culd_s));

	// A read address phase taken at this edge; read data and read-clear act on it.
	assign rd_take = hsel && hready && (htrans == olsr_pkg::HTRANS_NONSEQ) && !hwrite;

	// Any of the three loopback states counts as loopback.
	assign loop_any = center_loop_state_a | center_loop_state_b | terminal_loop_state;

	// First local status register: hardware bits and role-dependent software bits.
	always_comb begin
		stat1_next = stat1_reg;
		if (wr_stb && (acc_addr == olsr_pkg::OFF_STAT1) && !role_s) begin
			stat1_next[olsr_pkg::BIT_NOTIFY] = hwdata[olsr_pkg::BIT_NOTIFY];
			stat1_next[olsr_pkg::BIT_DIAG]   = hwdata[olsr_pkg::BIT_DIAG];
			stat1_next[olsr_pkg::BIT_CULD]   = hwdata[olsr_pkg::BIT_CULD];
		end
		if (role_s) begin
			stat1_next[olsr_pkg::BIT_NOTIFY] = notify_s;
			stat1_next[olsr_pkg::BIT_DIAG]   = diag_s;
			stat1_next[olsr_pkg::BIT_CULD]   = culd_s;
		end
		stat1_next[7] = 1'b0;
		stat1_next[olsr_pkg::BIT_ROLE] = role_s;
		stat1_next[olsr_pkg::BIT_LOOP] = loop_s;
		stat1_next[olsr_pkg::BIT_OSL] = !sd_s;
		stat1_next[olsr_pkg::BIT_PD] = !pdn_s;
	end

	// Second local status register.
	always_comb begin
		stat2_next = stat2_reg;
		if (wr_stb && (acc_addr == olsr_pkg::OFF_STAT2)) begin
			stat2_next[olsr_pkg::BIT_MULTI] = hwdata[olsr_pkg::BIT_MULTI] & !role_s;
		end
		if (role_s) begin
			stat2_next[olsr_pkg::BIT_MULTI] = 1'b0;
		end
		stat2_next[7:4] = olsr_pkg::STAT2_RST[7:4];
		stat2_next[1:0] = olsr_pkg::STAT2_RST[1:0];
		stat2_next[olsr_pkg::BIT_ANEG] = role_s & aneg_s;
	end

	// Shadow state: mirror while link up; center holds through warm reset.
	always_comb begin
		sh_state_next  = sh_state_reg;
		shadow_next    = shadow_reg;
		init_done_next = init_done_reg;
		case (sh_state_reg)
			olsr_pkg::OLSR_SH_INIT: begin
				if (strap_done_reg) begin
					sh_state_next = (role_s || !init_done_reg) ?
						olsr_pkg::OLSR_SH_MIRROR : olsr_pkg::OLSR_SH_HOLD;
				end
			end
			olsr_pkg::OLSR_SH_MIRROR: begin
				if (link_s) begin
					shadow_next    = partner_status;
					init_done_next = 1'b1;
				end else if (role_s || !init_done_reg) begin
					shadow_next = role_s ? olsr_pkg::SHADOW_RST_TERM : olsr_pkg::SHADOW_RST_CENTER;
				end
			end
			olsr_pkg::OLSR_SH_HOLD: begin
				// resume on link
				// The role is only known a few cycles after reset, so terminal leaves here too.
				if (link_s || role_s) begin
					sh_state_next = olsr_pkg::OLSR_SH_MIRROR;
				end
			end
			default: begin
				sh_state_next = olsr_pkg::OLSR_SH_INIT;
			end
		endcase
	end

	// Interrupt status: set wins over the clear done by a read.
	always_comb begin
		irq_st_next  = irq_st_reg;
		irq_msk_next = irq_msk_reg;
		if (rd_take && (haddr[9:2] == olsr_pkg::OFF_IRQ_ST)) begin
			irq_st_next = olsr_pkg::IRQ_NONE;
		end
		if (wr_stb && (acc_addr == olsr_pkg::OFF_IRQ_MSK)) begin
			irq_msk_next = hwdata[3:0];
		end
		if (shadow_next != shadow_reg) begin
			irq_st_next[olsr_pkg::IRQ_SHADOW] = 1'b1;
		end
		if (stat1_reg[olsr_pkg::BIT_OSL] && !osl_d_reg) begin
			irq_st_next[olsr_pkg::IRQ_OSL] = 1'b1;
		end
		if (stat1_reg[olsr_pkg::BIT_CULD] && !culd_d_reg) begin
			irq_st_next[olsr_pkg::IRQ_CULD] = 1'b1;
		end
		if (stat1_reg[olsr_pkg::BIT_LOOP] && !loop_d_reg) begin
			irq_st_next[olsr_pkg::IRQ_LOOP] = 1'b1;
		end
	end

	// Read data mux, loaded at the address phase so it stands through the data phase.
	always_comb begin
		rdata_next = rdata_reg;
		if (rd_take) begin
			rdata_next = 32'h0000_0000;
			case (haddr[9:2])
				olsr_pkg::OFF_SHADOW:  rdata_next[7:0] = shadow_reg;
				olsr_pkg::OFF_STAT1:   rdata_next[7:0] = stat1_reg;
				olsr_pkg::OFF_STAT2:   rdata_next[7:0] = stat2_reg;
				olsr_pkg::OFF_IRQ_ST:  rdata_next[3:0] = irq_st_reg;
				olsr_pkg::OFF_IRQ_MSK: rdata_next[3:0] = irq_msk_reg;
				default:               rdata_next = 32'h0000_0000;
			endcase
		end
	end

	// Registers cleared by warm reset.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			stat1_reg      <= olsr_pkg::STAT1_RST;
			stat2_reg      <= olsr_pkg::STAT2_RST;
			irq_st_reg     <= olsr_pkg::IRQ_NONE;
			irq_msk_reg    <= olsr_pkg::IRQ_NONE;
			rdata_reg      <= 32'h0000_0000;
			osl_d_reg      <= 1'b0;
			culd_d_reg     <= 1'b1;
			loop_d_reg     <= 1'b0;
			sh_state_reg   <= olsr_pkg::OLSR_SH_INIT;
			strap_done_reg <= 1'b0;
		end else begin
			stat1_reg      <= stat1_next;
			stat2_reg      <= stat2_next;
			irq_st_reg     <= irq_st_next;
			irq_msk_reg    <= irq_msk_next;
			rdata_reg      <= rdata_next;
			osl_d_reg      <= stat1_reg[olsr_pkg::BIT_OSL];
			culd_d_reg     <= stat1_reg[olsr_pkg::BIT_CULD];
			loop_d_reg     <= stat1_reg[olsr_pkg::BIT_LOOP];
			sh_state_reg   <= (!pdn_s) ? olsr_pkg::OLSR_SH_INIT : sh_state_next;
			strap_done_reg <= pdn_s;
		end
	end

	// The power-on marker survives warm reset, and so does the shadow in center role once a link has set it; only power-on clears the marker.
	always_ff @(posedge hclk or negedge por_n) begin
		if (!por_n) begin
			shadow_reg    <= olsr_pkg::SHADOW_RST_TERM;
			init_done_reg <= 1'b0;
		end else if (!hresetn) begin
			if (!init_done_reg || role_s) begin
				shadow_reg <= role_s ? olsr_pkg::SHADOW_RST_TERM : olsr_pkg::SHADOW_RST_CENTER;
			end
		end else if (!init_done_reg && (sh_state_reg == olsr_pkg::OLSR_SH_INIT)) begin
			shadow_reg <= role_s ? olsr_pkg::SHADOW_RST_TERM : olsr_pkg::SHADOW_RST_CENTER;
		end else begin
			shadow_reg    <= shadow_next;
			init_done_reg <= init_done_next;
		end
	end

	assign hrdata = rdata_reg;
	assign irq    = |(irq_st_reg & irq_msk_reg);
endmodule : oam_local_status_regs
`default_nettype wire

/* File: olsr_pkg.sv */
// Constants, register map and reset values for the local status register bank.
// Assumes a single 40 MHz clock and an AHB-Lite slave port with 32-bit data.
// Notes on behaviour
// - Terminal role: shadow mirrors partner status whenever optical link is up.
// - Center role: shadow copies after power-on, keeps value over warm reset, power down.
// - After link returns, center shadow resumes mirroring while link stays up.
// - Shadow resets to 0x07 in terminal role, 0x47 in center role.
// - Status bit 6 is read-only role: 1 terminal, 0 center.
// - Status bit 5 reads 1 in any loopback state, resets to 0.
// - Bit 4 loss-notify method: software in center role, pin in terminal role.
// - Bit 3 diagnostic fail: software in center role, pin in terminal role.
// - Bit 2 copper link down, resets 1; terminal role ignores writes.
// - Bit 1 reads 1 when fibre signal detect shows no signal.
// - Bit 0 is the inverse of the active-low power-down pin.
// - Second-status bit 3 writable in center role, held 0 in terminal role.
// - Second-status bit 2 shows autoneg strap in terminal role, 0 in center role.
// - Partner status uses the same bit layout as the first local status.
`default_nettype none
package olsr_pkg;
	localparam logic [7:0] OFF_SHADOW  = 8'h4f;
	localparam logic [7:0] OFF_STAT1   = 8'h50;
	localparam logic [7:0] OFF_STAT2   = 8'h51;
	localparam logic [7:0] OFF_PARTNER = 8'h58;
	localparam logic [7:0] OFF_IRQ_ST  = 8'h60;
	localparam logic [7:0] OFF_IRQ_MSK = 8'h61;
	localparam int         BIT_ROLE    = 6;
	localparam int         BIT_LOOP    = 5;
	localparam int         BIT_NOTIFY  = 4;
	localparam int         BIT_DIAG    = 3;
	localparam int         BIT_CULD    = 2;
	localparam int         BIT_OSL     = 1;
	localparam int         BIT_PD      = 0;
	localparam int         BIT_MULTI   = 3;
	localparam int         BIT_ANEG    = 2;
	localparam logic [7:0] SHADOW_RST_TERM   = 8'h07;
	localparam logic [7:0] SHADOW_RST_CENTER = 8'h47;
	localparam logic [7:0] PARTNER_RST_TERM  = 8'h07;
	localparam logic [7:0] PARTNER_RST_CENTER = 8'h47;
	localparam logic [7:0] STAT1_RST   = 8'h04;
	localparam logic [7:0] STAT2_RST   = 8'h00;
	localparam logic [3:0] STAT2_WMASK = 4'h8;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	// Interrupt status bits: shadow changed, optical loss, copper down, loopback entry.
	localparam int IRQ_SHADOW = 0;
	localparam int IRQ_OSL    = 1;
	localparam int IRQ_CULD   = 2;
	localparam int IRQ_LOOP   = 3;
	localparam logic [3:0] IRQ_NONE = 4'h0;
	typedef enum logic [1:0] {
		OLSR_SH_INIT   = 2'b00,
		OLSR_SH_MIRROR = 2'b01,
		OLSR_SH_HOLD   = 2'b10
	} olsr_shadow_state_t;
endpackage : olsr_pkg
`default_nettype wire

/* File: olsr_sync.sv */
// Three-flop synchroniser with agreement filter for one asynchronous pin.
// Assumes the pin is quasi-static compared with the 40 MHz clock.
`default_nettype none
module olsr_sync #(
	parameter logic RST_VAL = 1'b0
) (
	input  wire logic hclk,
	input  wire logic hresetn,
	input  wire logic pin_in,
	output var  logic level_out
);
	logic s1_reg;
	logic s2_reg;
	logic s3_reg;
	logic lvl_reg;
	logic lvl_next;

	// The filtered level moves only when the second and third stages agree.
	always_comb begin
		lvl_next = lvl_reg;
		if (s2_reg == s3_reg) begin
			lvl_next = s2_reg;
		end
	end

	// Stage chain; the first stage feeds only the second.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s1_reg  <= RST_VAL;
			s2_reg  <= RST_VAL;
			s3_reg  <= RST_VAL;
			lvl_reg <= RST_VAL;
		end else begin
			s1_reg  <= pin_in;
			s2_reg  <= s1_reg;
			s3_reg  <= s2_reg;
			lvl_reg <= lvl_next;
		end
	end

	assign level_out = lvl_reg;
endmodule : olsr_sync
`default_nettype wire

/* File: olsr_ahb_slave.sv */
// AHB-Lite slave front end: captures the address phase and raises one-cycle strobes.
// Assumes single word transfers; always OKAY and zero wait states.
`default_nettype none
module olsr_ahb_slave (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic        hready,
	output var  logic        hreadyout,
	output var  logic        hresp,
	output var  logic        wr_stb,
	output var  logic        rd_stb,
	output var  logic [7:0]  acc_addr
);
	logic       wr_reg;
	logic       wr_next;
	logic       rd_reg;
	logic       rd_next;
	logic [7:0] addr_reg;
	logic [7:0] addr_next;

	// A valid address phase is remembered for the following data phase.
	always_comb begin
		wr_next   = 1'b0;
		rd_next   = 1'b0;
		addr_next = addr_reg;
		if (hsel && hready && (htrans == olsr_pkg::HTRANS_NONSEQ)) begin
			wr_next   = hwrite;
			rd_next   = !hwrite;
			addr_next = haddr[9:2];
		end
	end

	// Address phase registers.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_reg   <= 1'b0;
			rd_reg   <= 1'b0;
			addr_reg <= 8'h00;
		end else begin
			wr_reg   <= wr_next;
			rd_reg   <= rd_next;
			addr_reg <= addr_next;
		end
	end

	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign wr_stb    = wr_reg;
	assign rd_stb    = rd_reg;
	assign acc_addr  = addr_reg;
endmodule : olsr_ahb_slave
`default_nettype wire

/* File: olsr_props.sv */
// Checker for the bus port of the local status register bank.
// Assumes it is bound to the top module and sees only its ports.
`default_nettype none
module olsr_props (
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [31:0] hwdata,
	input wire logic        hready,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic [31:0] hrdata,
	input wire logic        terminal_role
);
	localparam logic [31:0] A_ST1 = {22'h0, olsr_pkg::OFF_STAT1, 2'b00};
	localparam logic [31:0] A_ST2 = {22'h0, olsr_pkg::OFF_STAT2, 2'b00};
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// Address phases that the slave takes.
	sequence take_s(logic wr);
		hsel && hready && htrans == olsr_pkg::HTRANS_NONSEQ && hwrite == wr;
	endsequence
	sequence rd_at(logic [31:0] a);
		take_s(1'b0) ##0 haddr == a;
	endsequence
	sequence wr_at(logic [31:0] a);
		take_s(1'b1) ##0 haddr == a;
	endsequence
	chk_ready_okay: assert property (hreadyout && !hresp)
		else $error("slave not ready or not okay");
	chk_st1_upper: assert property (rd_at(A_ST1) |=> hrdata[31:7] == 25'h0)
		else $error("status one upper bits not zero");
	chk_st2_upper: assert property (rd_at(A_ST2) |=> hrdata[31:4] == 28'h0)
		else $error("status two upper bits not zero");
	chk_role_bit: assert property (rd_at(A_ST1) |=> hrdata[6] == $past(terminal_role))
		else $error("role bit differs from role pin");
	chk_term_multi: assert property (rd_at(A_ST2) ##0 terminal_role |=> !hrdata[3])
		else $error("interface count set in terminal role");
	chk_center_aneg: assert property (rd_at(A_ST2) ##0 !terminal_role |=> !hrdata[2])
		else $error("autoneg bit set in center role");
	chk_multi_write: assert property (wr_at(A_ST2) ##0 !terminal_role ##2 rd_at(A_ST2)
		|=> hrdata[3] == $past(hwdata[3], 2)) else $error("interface count write lost");
	chk_rdata_holds: assert property
		(!(hsel && hready && htrans == olsr_pkg::HTRANS_NONSEQ && !hwrite) |=> $stable(hrdata))
		else $error("read data changed without a read");
endmodule : olsr_props
bind oam_local_status_regs olsr_props olsr_props_i (.hclk(hclk), .hresetn(hresetn),
	.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
	.hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
	.terminal_role(terminal_role));
`default_nettype wire

/* File: olsr_partner.sv */
// Model of the remote converter: optical link state and received status byte.
// Assumes drive is called just after a rising clock edge.
`default_nettype none
module olsr_partner (
	input  wire logic       hclk,
	output var  logic       opt_link_up,
	output var  logic [7:0] partner_status
);
	timeunit 1ns;
	timeprecision 100ps;
	logic       up = 1'b0;
	logic [7:0] last = 8'h07;
	// same bit layout
	// The received byte keeps the last frame's value while the link is down.
	always_comb begin
		opt_link_up    = up;
		partner_status = last;
	end
	// Changes the link and, while up, the status byte.
	task automatic drive(input logic u, input logic [7:0] s);
		up <= u;
		if (u) begin
			last <= s;
		end
	endtask : drive
endmodule : olsr_partner
`default_nettype wire

/* File: tb_top.sv */
// Self-checking bench for the local status register bank.
// Assumes one 40 MHz clock; the bench is the only bus master.
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic        hclk = 1'b0, hresetn = 1'b0, por_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
	logic [1:0]  htrans = 2'h0;
	logic        hready, hreadyout, hresp, irq, up;
	logic [7:0]  pst, v;
	logic        role = 1'b1, la = 1'b0, lb = 1'b0, lt = 1'b0, notify = 1'b0, diag = 1'b0;
	logic        culd = 1'b1, sd = 1'b1, pd_n = 1'b1;
	int          n_mismatch = 0, comparisons = 0, cyc = 0;
	assign hready = hreadyout;
	oam_local_status_regs oam_local_status_regs_i (.hclk(hclk), .hresetn(hresetn),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
		.hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .por_n(por_n), .terminal_role(role), .center_loop_state_a(la),
		.center_loop_state_b(lb), .terminal_loop_state(lt), .loss_notify_pin(notify),
		.diag_fail_pin(diag), .copper_link_down_hw(culd), .fibre_signal_detect_pin(sd),
		.power_down_pin_n(pd_n), .copper_autoneg_strap(1'b1), .opt_link_up(up),
		.partner_status(pst), .irq(irq));
	olsr_partner olsr_partner_i (.hclk(hclk), .opt_link_up(up), .partner_status(pst));
	// Clock and the run-time ceiling.
	always #12.5 hclk = ~hclk;
	always @(posedge hclk) begin
		cyc++;
		if (cyc == 6000) begin
			n_mismatch++;
			results();
		end
	end
	// One single AHB-Lite word transfer, entered just after a rising edge.
	task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
			output logic [7:0] rd);
		hsel <= 1'b1;
		htrans <= olsr_pkg::HTRANS_NONSEQ;
		haddr <= {22'h0, idx, 2'b00};
		hwrite <= wr;
		do @(posedge hclk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= {24'h0, wd};
		do @(posedge hclk); while (hready !== 1'b1);
		rd = hrdata[7:0];
	endtask : bus
	task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		comparisons++;
		if (got !== exp) begin
			$display("[ERR] %s expected %h seen %h", name, exp, got);
			n_mismatch++;
		end
	endtask : chk
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		logic [7:0] dummy;
		bus(1'b1, idx, d, dummy);
	endtask : wr
	task automatic rchk(input string name, input logic [7:0] idx, input logic [7:0] exp);
		logic [7:0] got;
		bus(1'b0, idx, 8'h00, got);
		chk(name, exp, got);
	endtask : rchk
	// Looks at the interrupt line mid-cycle, then returns on a rising edge.
	task automatic ichk(input logic e);
		@(negedge hclk);
		chk("irq", {7'h0, e}, {7'h0, irq});
		@(posedge hclk);
	endtask : ichk
	task automatic rst(input logic por);
		hresetn <= 1'b0;
		por_n <= !por;
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		por_n <= 1'b1;
		repeat (10) @(posedge hclk);
	endtask : rst
	task automatic settle();
		repeat (10) @(posedge hclk);
	endtask : settle
	task automatic results();
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : results
	// Main sequence: terminal role first, then center role.
	initial begin
		rst(1'b1);
		rchk("shadow", olsr_pkg::OFF_SHADOW, 8'h07);
		rchk("stat1", olsr_pkg::OFF_STAT1, 8'h44);
		rchk("stat2", olsr_pkg::OFF_STAT2, 8'h04);
		$display("test terminal reset done");
		{notify, diag, culd, sd, pd_n, la} <= 6'b110001;
		wr(olsr_pkg::OFF_STAT1, 8'h04);
		settle();
		rchk("stat1", olsr_pkg::OFF_STAT1, 8'h7b);
		for (int i = 0; i < 3; i++) begin
			{la, lb, lt} <= 3'b001 << i;
			settle();
			rchk("stat1", olsr_pkg::OFF_STAT1, 8'h7b);
		end
		{la, lb, lt} <= 3'b000;
		settle();
		rchk("stat1", olsr_pkg::OFF_STAT1, 8'h5b);
		wr(olsr_pkg::OFF_STAT2, 8'h08);
		wr(8'h3f, 8'hff);
		rchk("stat2", olsr_pkg::OFF_STAT2, 8'h04);
		{notify, diag, culd, sd, pd_n} <= 5'b00111;
		settle();
		rchk("stat1", olsr_pkg::OFF_STAT1, 8'h44);
		$display("test terminal pins done");
		bus(1'b0, olsr_pkg::OFF_IRQ_ST, 8'h00, v);
		wr(olsr_pkg::OFF_IRQ_MSK, 8'h00);
		olsr_partner_i.drive(1'b1, 8'h5a);
		settle();
		rchk("shadow", olsr_pkg::OFF_SHADOW, 8'h5a);
		ichk(1'b0);
		wr(olsr_pkg::OFF_IRQ_MSK, 8'h01);
		ichk(1'b1);
		rchk("irq status", olsr_pkg::OFF_IRQ_ST, 8'h01);
		ichk(1'b0);
		olsr_partner_i.drive(1'b1, 8'h33);
		settle();
		rchk("shadow", olsr_pkg::OFF_SHADOW, 8'h33);
		wr(olsr_pkg::OFF_IRQ_MSK, 8'h00);
		olsr_partner_i.drive(1'b0, 8'h33);
		$display("test terminal shadow done");
		role <= 1'b0;
		rst(1'b1);
		rchk("shadow", olsr_pkg::OFF_SHADOW, 8'h47);
		rchk("stat1", olsr_pkg::OFF_STAT1, 8'h04);
		rchk("stat2", olsr_pkg::OFF_STAT2, 8'h00);
		wr(olsr_pkg::OFF_STAT1, 8'h1c);
		rchk("stat1", olsr_pkg::OFF_STAT1, 8'h1c);
		wr(olsr_pkg::OFF_STAT1, 8'h00);
		rchk("stat1", olsr_pkg::OFF_STAT1, 8'h00);
		wr(olsr_pkg::OFF_STAT2, 8'h08);
		rchk("stat2", olsr_pkg::OFF_STAT2, 8'h08);
		olsr_partner_i.drive(1'b1, 8'h21);
		settle();
		rchk("shadow", olsr_pkg::OFF_SHADOW, 8'h21);
		olsr_partner_i.drive(1'b0, 8'h21);
		settle();
		rst(1'b0);
		rchk("shadow", olsr_pkg::OFF_SHADOW, 8'h21);
		olsr_partner_i.drive(1'b1, 8'h12);
		settle();
		rchk("shadow", olsr_pkg::OFF_SHADOW, 8'h12);
		olsr_partner_i.drive(1'b0, 8'h12);
		pd_n <= 1'b0;
		settle();
		pd_n <= 1'b1;
		settle();
		rchk("shadow", olsr_pkg::OFF_SHADOW, 8'h12);
		olsr_partner_i.drive(1'b1, 8'h35);
		settle();
		rchk("shadow", olsr_pkg::OFF_SHADOW, 8'h35);
		olsr_partner_i.drive(1'b0, 8'h35);
		rst(1'b1);
		rchk("shadow", olsr_pkg::OFF_SHADOW, 8'h47);
		$display("test center shadow done");
		results();
	end
endmodule : tb_top
`default_nettype wire
